// ### inc/jet_mode_pkg.sv
// Shared constants and types for the reaction-jet mode controller.
// Assumes a 100 MHz REF_CLK and a control cycle derived from it.
package jet_mode_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int IMPULSE_MS = 14;
    localparam int IMPULSE_CYC = IMPULSE_MS * 1000 * CLK_MHZ;
    localparam int CTRL_CYCLE_MS = 100;
    localparam int CTRL_CYCLE_CYC = CTRL_CYCLE_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // APB register map (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CONFIG_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] AUTO_CMD_OFS = 8'h0C;
    localparam logic [7:0] JET_OFS = 8'h10;

    // CTRL fields
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_RESUME_BIT = 1;
    localparam int CTRL_SEP_ACK_BIT = 2;
    localparam int CTRL_OFF_BIT = 3;
    // CONFIG fields
    localparam int CFG_RATE_LSB = 0;
    localparam int CFG_DB_BIT = 2;
    localparam int CFG_QUAD_LSB = 4;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_00F0;

    // Rate table, milli-deg/sec, index by 2-bit code
    localparam logic [11:0] RATE_MDPS [4] = '{12'h032, 12'h0C8, 12'h1F4, 12'h7D0};
    // Deadband, centi-deg
    localparam logic [9:0] DB_SMALL_CDEG = 10'h032;
    localparam logic [9:0] DB_LARGE_CDEG = 10'h1F4;
    // Control-axis tilt about navigation X, centi-deg (-7.25 deg)
    localparam logic signed [11:0] AXIS_TILT_CDEG = -12'sd725;

    typedef enum logic [1:0] {SW_FREE = 2'h0, SW_HOLD = 2'h1, SW_AUTO = 2'h2} mode_sw_t;

    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_RJ = 5'b00010,
        ST_THRUST = 5'b00100,
        ST_REENTRY = 5'b01000,
        ST_SUSPEND = 5'b10000
    } ap_state_t;

    // Six discretes per hand controller: +x,-x,+y,-y,+z,-z
    typedef struct packed {
        logic [5:0] rot;
        logic [5:0] trans;
        logic [5:0] mimp;
    } hand_t;

    typedef struct packed {
        logic [5:0] rot;
        logic [5:0] trans;
    } jet_cmd_t;
endpackage : jet_mode_pkg

// ### rtl/reaction_jet_mode_control.sv
// Mode selection and command arbitration of the coasting reaction-jet autopilot.
// Assumes switch and hand-controller pins are asynchronous; APB on REF_CLK.
//
// How it works
// - Non-FREE needs inertial mode and computer source
// - Mode switch picks AUTO, HOLD or FREE
// - Only this autopilot heeds switch and hands
// - Source switch away stops control, return resumes
// - Ignition hands to thrust steering, cutoff back
// - Reentry only after attitude, separation, acknowledge
// - Jet commands leave on channels 5, 6
// - FREE: rotation detent exit gives one impulse
// - FREE: min-impulse used when rotation idle
// - FREE: no commands means drift
// - HOLD: hold captured attitude when idle
// - Rotation overrides hold; recapture after detent
// - HOLD, AUTO ignore min-impulse input
// - Control axes tilted -7.25 deg about X
// - AUTO idle follows automatic steering commands
// - Rotation overrides AUTO; resume on keypad
// - AUTO without steering acts like HOLD
// - Translation merged in every mode
// - Quad failure: any rotation command drops all translation
// - One load command steps three displays
// - Two-bit code selects maneuver rate
// - One bit selects deadband
`timescale 1ns/100ps
module reaction_jet_mode_control
    import jet_mode_pkg::*;
#(
    parameter int IMPULSE_CYCLES = IMPULSE_CYC,
    parameter int CTRL_CYCLES = CTRL_CYCLE_CYC
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [1:0] MODE_SWITCH,
    input wire logic CONTROL_SOURCE_SWITCH,
    input wire logic INERTIAL_MODE,
    input wire hand_t HAND_IN,
    input wire logic BURN_IGNITION,
    input wire logic BURN_CUTOFF,
    input wire logic SEP_ATTITUDE,
    input wire logic SEPARATED,
    input wire logic [31:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [5:0] JET_CHANNEL5,
    output logic [5:0] JET_CHANNEL6,
    output logic THRUST_STEER_ACTIVE,
    output logic REENTRY_ACTIVE
);
    // ==========================================================
    // Input synchronisers
    logic [1:0] mode_s1_q, mode_q;
    logic src_s1_q, src_q, ins_s1_q, ins_q;
    hand_t hand_s1_q, hand_q;
    logic ign_s1_q, ign_q, cut_s1_q, cut_q, satt_s1_q, satt_q, sep_s1_q, sep_q;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mode_s1_q <= 2'h0;
            mode_q <= 2'h0;
            src_s1_q <= 1'b0;
            src_q <= 1'b0;
            ins_s1_q <= 1'b0;
            ins_q <= 1'b0;
            hand_s1_q <= '0;
            hand_q <= '0;
            ign_s1_q <= 1'b0;
            ign_q <= 1'b0;
            cut_s1_q <= 1'b0;
            cut_q <= 1'b0;
            satt_s1_q <= 1'b0;
            satt_q <= 1'b0;
            sep_s1_q <= 1'b0;
            sep_q <= 1'b0;
        end else begin
            mode_s1_q <= MODE_SWITCH;
            mode_q <= mode_s1_q;
            src_s1_q <= CONTROL_SOURCE_SWITCH;
            src_q <= src_s1_q;
            ins_s1_q <= INERTIAL_MODE;
            ins_q <= ins_s1_q;
            hand_s1_q <= HAND_IN;
            hand_q <= hand_s1_q;
            ign_s1_q <= BURN_IGNITION;
            ign_q <= ign_s1_q;
            cut_s1_q <= BURN_CUTOFF;
            cut_q <= cut_s1_q;
            satt_s1_q <= SEP_ATTITUDE;
            satt_q <= satt_s1_q;
            sep_s1_q <= SEPARATED;
            sep_q <= sep_s1_q;
        end
    end

    // ==========================================================
    // Control-cycle tick
    logic [31:0] cyc_cnt_q;
    logic tick;
    // Detent sampling and impulse starts wait for this tick
    assign tick = (cyc_cnt_q == 32'(CTRL_CYCLES - 1));

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cyc_cnt_q <= 32'h0000_0000;
        end else if (tick) begin
            cyc_cnt_q <= 32'h0000_0000;
        end else begin
            cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Registers
    logic on_req, off_req, resume_req, ack_req;
    logic [31:0] config_q, auto_cmd_q;
    logic wr_en, rd_en, addr_ok;
    logic [7:0] offs;

    assign offs = PADDR[7:0];
    assign addr_ok = (PADDR[31:8] == 24'h00_0000) && (offs == CTRL_OFS || offs == CONFIG_OFS
        || offs == STATUS_OFS || offs == AUTO_CMD_OFS || offs == JET_OFS);
    assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    // No wait states: each access ends in its first access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign on_req = wr_en && offs == CTRL_OFS && PWDATA[CTRL_ON_BIT];
    assign off_req = wr_en && offs == CTRL_OFS && PWDATA[CTRL_OFF_BIT];
    assign resume_req = wr_en && offs == CTRL_OFS && PWDATA[CTRL_RESUME_BIT];
    assign ack_req = wr_en && offs == CTRL_OFS && PWDATA[CTRL_SEP_ACK_BIT];

    // Rate, deadband and quad health loaded as one word, like one load command
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            config_q <= CONFIG_RESET;
        end else if (wr_en && offs == CONFIG_OFS && !THRUST_STEER_ACTIVE) begin
            config_q <= {24'h00_0000, PWDATA[7:0]};
        end
    end

    // Bits 5:0 rotation request, bit 8 request valid
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            auto_cmd_q <= 32'h0000_0000;
        end else if (wr_en && offs == AUTO_CMD_OFS) begin
            auto_cmd_q <= {23'h00_0000, PWDATA[8], 2'h0, PWDATA[5:0]};
        end
    end

    logic [11:0] rate_mdps;
    logic [9:0] db_cdeg;
    logic [3:0] quad_ok;
    assign rate_mdps = RATE_MDPS[config_q[CFG_RATE_LSB +: 2]];
    assign db_cdeg = config_q[CFG_DB_BIT] ? DB_LARGE_CDEG : DB_SMALL_CDEG;
    assign quad_ok = config_q[CFG_QUAD_LSB +: 4];

    // ==========================================================
    // Autopilot ownership
    ap_state_t state_q;
    logic rj_enabled;
    logic sep_acked_q;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sep_acked_q <= 1'b0;
        end else if (ack_req && satt_q && sep_q) begin
            sep_acked_q <= 1'b1;
        end else if (state_q == ST_REENTRY || off_req) begin
            sep_acked_q <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_q <= ST_OFF;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    if (on_req) begin
                        state_q <= ST_RJ;
                    end
                end
                ST_RJ: begin
                    if (off_req) begin
                        state_q <= ST_OFF;
                    end else if (ign_q) begin
                        state_q <= ST_THRUST;
                    end else if (sep_acked_q && satt_q && sep_q) begin
                        state_q <= ST_REENTRY;
                    end else if (!src_q) begin
                        state_q <= ST_SUSPEND;
                    end
                end
                ST_SUSPEND: begin
                    if (off_req) begin
                        state_q <= ST_OFF;
                    end else if (src_q) begin
                        state_q <= ST_RJ;
                    end
                end
                ST_THRUST: begin
                    if (cut_q) begin
                        state_q <= ST_RJ;
                    end
                end
                // Final state: only reset leaves reentry
                ST_REENTRY: begin
                    state_q <= ST_REENTRY;
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    assign THRUST_STEER_ACTIVE = (state_q == ST_THRUST);
    assign REENTRY_ACTIVE = (state_q == ST_REENTRY);
    // Hands and switch reach only this autopilot
    assign rj_enabled = (state_q == ST_RJ) && src_q;

    // FREE runs without the platform; other modes need it
    logic free_mode, mode_ok;
    assign free_mode = (mode_q == SW_FREE);
    assign mode_ok = free_mode || (ins_q && src_q);

    // ==========================================================
    // Detent exits per control cycle
    logic [5:0] rot_prev_q, mimp_prev_q;
    logic [5:0] rot_exit, mimp_exit;
    assign rot_exit = hand_q.rot & ~rot_prev_q;
    assign mimp_exit = hand_q.mimp & ~mimp_prev_q;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rot_prev_q <= 6'h00;
            mimp_prev_q <= 6'h00;
        end else if (tick) begin
            rot_prev_q <= hand_q.rot;
            mimp_prev_q <= hand_q.mimp;
        end
    end

    // ==========================================================
    // Impulse firing timer
    logic [31:0] imp_cnt_q;
    logic [5:0] imp_axes_q;

    // Loaded one short, so the jets stand exactly IMPULSE_CYCLES clocks
    always_ff @(posedge REF_CLK) begin
        if (RST || !rj_enabled || !free_mode) begin
            imp_cnt_q <= 32'h0000_0000;
            imp_axes_q <= 6'h00;
        end else if (tick && |rot_exit) begin
            imp_cnt_q <= 32'(IMPULSE_CYCLES - 1);
            imp_axes_q <= rot_exit;
        end else if (tick && hand_q.rot == 6'h00 && |mimp_exit) begin
            imp_cnt_q <= 32'(IMPULSE_CYCLES - 1);
            imp_axes_q <= mimp_exit;
        end else if (imp_cnt_q != 32'h0000_0000) begin
            imp_cnt_q <= imp_cnt_q - 32'h0000_0001;
        end else begin
            imp_axes_q <= 6'h00;
        end
    end

    // ==========================================================
    // Hold and auto steering
    logic hold_capture_q, auto_override_q;
    logic manual_rot;
    assign manual_rot = hand_q.rot != 6'h00;

    // Mode at the previous control cycle; only the second sync flop is read
    logic [1:0] mode_prev_q;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mode_prev_q <= SW_FREE;
        end else if (tick) begin
            mode_prev_q <= mode_q;
        end
    end

    // Capture pulse on entering HOLD or AUTO, or on stick returning to detent
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            hold_capture_q <= 1'b0;
        end else begin
            hold_capture_q <= rj_enabled && !free_mode && tick
                && ((rot_prev_q != 6'h00 && !manual_rot)
                || mode_q != mode_prev_q);
        end
    end

    // Stick activity freezes automatic maneuver until keypad resume
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            auto_override_q <= 1'b0;
        end else if (rj_enabled && mode_q == SW_AUTO && manual_rot) begin
            auto_override_q <= 1'b1;
        end else if (resume_req) begin
            auto_override_q <= 1'b0;
        end
    end

    logic auto_steer;
    assign auto_steer = (mode_q == SW_AUTO) && auto_cmd_q[8] && !auto_override_q;

    // ==========================================================
    // Jet command merge
    jet_cmd_t jet_d;
    logic [5:0] rot_sel, trans_sel;
    logic quad_failed;
    assign quad_failed = quad_ok != 4'hF;

    always_comb begin
        rot_sel = 6'h00;
        if (free_mode) begin
            rot_sel = imp_axes_q;
        end else if (manual_rot) begin
            rot_sel = hand_q.rot;
        end else if (auto_steer) begin
            rot_sel = auto_cmd_q[5:0];
        end
        // Min-impulse input never reaches rot_sel outside FREE
        trans_sel = hand_q.trans;
        if (quad_failed && rot_sel != 6'h00) begin
            trans_sel = 6'h00;
        end
        // Rotation also needs the platform outside FREE
        jet_d.rot = (rj_enabled && mode_ok) ? rot_sel : 6'h00;
        jet_d.trans = rj_enabled ? trans_sel : 6'h00;
    end

    // Outputs hold the control-axis frame, tilted AXIS_TILT_CDEG from nav base
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            JET_CHANNEL5 <= 6'h00;
            JET_CHANNEL6 <= 6'h00;
        end else begin
            JET_CHANNEL5 <= jet_d.trans;
            JET_CHANNEL6 <= jet_d.rot;
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        PRDATA = 32'h0000_0000;
        if (rd_en) begin
            unique case (offs)
                CTRL_OFS: PRDATA = {27'h000_0000, state_q};
                CONFIG_OFS: PRDATA = config_q;
                STATUS_OFS: PRDATA = {8'h00, rate_mdps, db_cdeg, hold_capture_q,
                    auto_override_q};
                AUTO_CMD_OFS: PRDATA = auto_cmd_q;
                JET_OFS: PRDATA = {20'h0_0000, JET_CHANNEL5, JET_CHANNEL6};
                default: PRDATA = 32'h0000_0000;
            endcase
        end
    end
endmodule : reaction_jet_mode_control

// ### dv/reaction_jet_mode_control_properties.sv
// Port-level checks of the reaction-jet mode controller.
// Bound into the top module; one clock, synchronous reset.
`timescale 1ns/100ps
module jet_mode_checker
    import jet_mode_pkg::*;
#(
    parameter int IMPULSE_CYCLES = 20,
    parameter int CTRL_CYCLES = 50
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [1:0] MODE_SWITCH,
    input wire logic BURN_IGNITION,
    input wire logic BURN_CUTOFF,
    input wire logic SEP_ATTITUDE,
    input wire logic SEPARATED,
    input wire logic [5:0] JET_CHANNEL5,
    input wire logic [5:0] JET_CHANNEL6,
    input wire logic THRUST_STEER_ACTIVE,
    input wire logic REENTRY_ACTIVE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    // ====================
    // Length of a jet run
    logic [31:0] run_q;
    always_ff @(posedge REF_CLK) begin
        if (RST || JET_CHANNEL6 == 6'h00) begin
            run_q <= '0;
        end else begin
            run_q <= run_q + 32'h0000_0001;
        end
    end
    sequence burn_steady;
        THRUST_STEER_ACTIVE [*4];
    endsequence
    sequence entry_steady;
        REENTRY_ACTIVE [*4];
    endsequence
    // ====================
    // Properties
    a_reset_jets_off:
        assert property ($past(RST) |-> {JET_CHANNEL5, JET_CHANNEL6, THRUST_STEER_ACTIVE,
            REENTRY_ACTIVE} == 14'h0000) else $error("outputs on after reset");
    a_impulse_width:
        assert property (MODE_SWITCH == SW_FREE && run_q != 0 && JET_CHANNEL6 == 6'h00
            |-> run_q == 32'(IMPULSE_CYCLES)) else $error("impulse width off");
    a_thrust_cause:
        assert property ($rose(THRUST_STEER_ACTIVE) |-> BURN_IGNITION)
            else $error("thrust steering without ignition");
    a_cutoff_return:
        assert property (THRUST_STEER_ACTIVE && BURN_CUTOFF |-> ##[1:8] !THRUST_STEER_ACTIVE)
            else $error("cutoff ignored");
    a_thrust_quiet:
        assert property (burn_steady |-> JET_CHANNEL5 == 6'h00 && JET_CHANNEL6 == 6'h00)
            else $error("jets fire during burn");
    a_entry_cause:
        assert property ($rose(REENTRY_ACTIVE) |-> SEP_ATTITUDE && SEPARATED)
            else $error("reentry before separation");
    a_entry_hold:
        assert property (REENTRY_ACTIVE |=> REENTRY_ACTIVE) else $error("reentry dropped");
    a_entry_quiet:
        assert property (entry_steady |-> JET_CHANNEL5 == 6'h00 && JET_CHANNEL6 == 6'h00)
            else $error("jets fire in reentry");
endmodule : jet_mode_checker
bind reaction_jet_mode_control jet_mode_checker #(
    .IMPULSE_CYCLES(IMPULSE_CYCLES),
    .CTRL_CYCLES(CTRL_CYCLES)
) checker_i (.*);

// ### dv/crew_panel_model.sv
// Crew hand controllers: one deflection held for a set time.
// Assumes the bench pulses go for one clock per stroke.
`timescale 1ns/100ps
module crew_panel_model
    import jet_mode_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire hand_t pat,
    input wire logic [7:0] len,
    output hand_t hand
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            hand <= '0;
            cnt_q <= '0;
        end else if (go) begin
            hand <= pat;
            cnt_q <= len;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else begin
            hand <= '0; // Back to detent
        end
    end
endmodule : crew_panel_model

// ### dv/reaction_jet_mode_control_tb.sv
// Self-checking bench for the reaction-jet mode controller.
// Assumes the panel model and the bound checker are compiled first.
`timescale 1ns/100ps
module reaction_jet_mode_control_tb;
    import jet_mode_pkg::*;
    localparam int IMP = 20;
    localparam int CYC = 50;
    logic clk, rst, psel, pen, pwr, src, inr, ign, cut, sat, sep, go, prdy, perr, er, ts, re;
    logic [1:0] mode;
    logic [31:0] pa, pwd, prd, rd;
    logic [5:0] ch5, ch6, ax, tr;
    logic [7:0] len;
    hand_t pat, hand;
    int err_total, n_compared;
    int ticks = 0;
    crew_panel_model crew (.clk(clk), .rst(rst), .go(go), .pat(pat), .len(len), .hand(hand));
    reaction_jet_mode_control #(.IMPULSE_CYCLES(IMP), .CTRL_CYCLES(CYC)) dut (
        .REF_CLK(clk), .RST(rst), .MODE_SWITCH(mode), .CONTROL_SOURCE_SWITCH(src),
        .INERTIAL_MODE(inr), .HAND_IN(hand), .BURN_IGNITION(ign), .BURN_CUTOFF(cut),
        .SEP_ATTITUDE(sat), .SEPARATED(sep), .PADDR(pa), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .JET_CHANNEL5(ch5), .JET_CHANNEL6(ch6), .THRUST_STEER_ACTIVE(ts),
        .REENTRY_ACTIVE(re));
    // ====================
    // Helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h, want %h", $time, g, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    // Waits for PREADY however long it takes; only the bench timeout ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= {24'h00_0000, a};
        pwd <= d;
        @(posedge clk) pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic stroke(input hand_t p, input logic [7:0] l);
        pat <= p;
        len <= l;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
    endtask : stroke
    // Held stick spans two ticks, so a second firing would show
    task automatic fire(input hand_t p, input logic [5:0] m, input int e);
        int n;
        n = 0;
        stroke(p, 8'd100);
        repeat (4 * CYC) begin
            @(posedge clk);
            if (ch6 !== 6'h00) n += (ch6 === m) ? 1 : 1000;
        end
        chk(n, e);
    endtask : fire
    task automatic level(input hand_t p, input logic [11:0] e);
        stroke(p, 8'd150);
        idle(2 * CYC);
        chk({ch5, ch6}, e);
        idle(3 * CYC);
    endtask : level
    function automatic logic [11:0] rate_of(input logic [1:0] c);
        case (c)
            2'h0: return 12'h032;
            2'h1: return 12'h0C8;
            2'h2: return 12'h1F4;
            default: return 12'h7D0;
        endcase
    endfunction : rate_of
    // ====================
    // Clock and timeout
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        ticks++;
        if (ticks == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // ====================
    // Scenarios
    initial begin
        rst = 1'b1;
        {psel, pen, pwr, src, inr, ign, cut, sat, sep, go} = '0;
        {mode, pa, pwd, pat, len} = '0;
        err_total = 0;
        n_compared = 0;
        ax = 6'h01 << ($urandom(82) % 6);
        tr = 6'($urandom) | 6'h01;
        idle(12);
        rst <= 1'b0;
        src <= 1'b1;
        @(posedge clk);
        chk({ch5, ch6, ts, re}, 0);
        bus(0, CTRL_OFS, 0);
        chk(rd, ST_OFF);
        bus(0, CONFIG_OFS, 0);
        chk(rd, CONFIG_RESET);
        bus(0, 8'h40, 0);
        chk(er, 1'b1);
        fire({ax, 12'h000}, 6'h00, 0);
        bus(1, CTRL_OFS, 32'h0000_0001);
        bus(0, CTRL_OFS, 0);
        chk(rd, ST_RJ);
        fire({ax, 12'h000}, ax, IMP);
        fire({12'h000, ax}, ax, IMP);
        fire({ax, 6'h00, ~ax}, ax, IMP);
        fire('0, 6'h00, 0);
        inr <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            mode <= 2'(m);
            level({6'h00, tr, 6'h00}, {tr, 6'h00});
        end
        mode <= SW_HOLD;
        level({ax, 6'h00, ~ax}, {6'h00, ax});
        inr <= 1'b0;
        level({ax, 12'h000}, 12'h000);
        inr <= 1'b1;
        bus(1, CONFIG_OFS, 0);
        level({ax, tr, 6'h00}, {6'h00, ax});
        bus(1, CONFIG_OFS, CONFIG_RESET);
        level({ax, tr, 6'h00}, {tr, ax});
        mode <= SW_AUTO;
        bus(1, AUTO_CMD_OFS, 32'h0000_0100 | 32'(tr));
        level('0, {6'h00, tr});
        level({ax, 12'h000}, {6'h00, ax});
        chk(ch6, 6'h00);
        bus(0, STATUS_OFS, 0);
        chk(rd[0], 1'b1);
        bus(1, CTRL_OFS, 32'h0000_0002);
        level('0, {6'h00, tr});
        bus(1, AUTO_CMD_OFS, 0);
        level('0, 12'h000);
        for (int c = 0; c < 8; c++) begin
            bus(1, CONFIG_OFS, 32'h0000_00F0 | c);
            idle(CYC + 5);
            bus(0, STATUS_OFS, 0);
            chk(rd[23:2], {rate_of(c[1:0]), c[2] ? 10'h1F4 : 10'h032});
        end
        src <= 1'b0;
        idle(CYC);
        bus(0, CTRL_OFS, 0);
        chk(rd, ST_SUSPEND);
        level({ax, tr, 6'h00}, 12'h000);
        src <= 1'b1;
        idle(CYC);
        bus(0, CTRL_OFS, 0);
        chk(rd, ST_RJ);
        ign <= 1'b1;
        idle(CYC);
        chk(ts, 1'b1);
        bus(1, CONFIG_OFS, 32'h0000_0003);
        bus(0, CONFIG_OFS, 0);
        chk(rd, 32'h0000_00F7);
        level({ax, tr, 6'h00}, 12'h000);
        ign <= 1'b0;
        cut <= 1'b1;
        idle(CYC);
        chk(ts, 1'b0);
        cut <= 1'b0;
        sat <= 1'b1;
        bus(1, CTRL_OFS, 32'h0000_0004);
        idle(CYC);
        chk(re, 1'b0);
        sep <= 1'b1;
        idle(CYC);
        chk(re, 1'b0);
        bus(1, CTRL_OFS, 32'h0000_0004);
        idle(CYC);
        chk(re, 1'b1);
        level({ax, tr, 6'h00}, 12'h000);
        tally_and_finish();
    end
endmodule : reaction_jet_mode_control_tb
